// [logic/spisc_defines.svh]
// Register map, field positions, reset values and counts of the SPI port
`ifndef SPISC_DEFINES_SVH
`define SPISC_DEFINES_SVH

// Register byte offsets
`define SPISC_OFF_MODE     12'h000
`define SPISC_OFF_LINK     12'h004
`define SPISC_OFF_DATA     12'h008

// serial_mode_control fields
`define SPISC_SEL_HI       7
`define SPISC_SEL_LO       5
`define SPISC_RSV          4
`define SPISC_EN           1
`define SPISC_ICF          0
`define SPISC_MODE_WMASK   8'hEF
`define SPISC_MODE_RST     8'hE0

// serial_link_control_status fields
`define SPISC_POL          5
`define SPISC_EDGE         4
`define SPISC_ORDER        3
`define SPISC_SELECT_PIN_ENABLE         2
`define SPISC_WRITE_COLLISION_FLAG         1
`define SPISC_TRF          0
`define SPISC_LINK_RST     8'h00
`define SPISC_DATA_RST     8'h00

// op_mode_select codes
`define SPISC_M_DIV4       3'h0
`define SPISC_M_DIV16      3'h1
`define SPISC_M_DIV64      3'h2
`define SPISC_M_SUB        3'h3
`define SPISC_M_TMR        3'h4
`define SPISC_M_SLAVE      3'h5

// Half serial clock periods in pclk cycles, edges and bits per byte
`define SPISC_HALF_DIV4    6'h02
`define SPISC_HALF_DIV16   6'h08
`define SPISC_HALF_DIV64   6'h20
`define SPISC_EDGES        5'h10
`define SPISC_BITS         4'h8
`define SPISC_SYNC_RST     4'hF

`endif

// [logic/spisc_pkg.sv]
// Types shared by the SPI port modules
package spisc_pkg;

  typedef enum logic [1:0] {
    SPISC_IDLE = 2'h0,
    SPISC_MRUN = 2'h1,
    SPISC_SRUN = 2'h3
  } spisc_state_e;

  typedef logic [3:0] spisc_pins_t;

  typedef struct packed {
    spisc_pins_t q1;
    spisc_pins_t q2;
    spisc_pins_t q3;
    spisc_pins_t st;
  } spisc_sync_s;

  typedef struct packed {
    logic [7:0]   mode;
    logic [7:0]   link;
    logic [7:0]   data;
    logic [7:0]   rdata;
    spisc_state_e st;
    logic [4:0]   edge_n;
    logic [3:0]   bits;
    logic [5:0]   div;
    logic         sck;
    spisc_pins_t  pin_d;
    logic         irq;
    logic [4:0]   cap;
    logic [7:0]   rx;
  } spisc_core_s;

endpackage : spisc_pkg

// [logic/spisc_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "spisc_defines.svh"

module spisc_sync (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Asynchronous pins and their filtered levels
  input  wire spisc_pkg::spisc_pins_t din,
  output spisc_pkg::spisc_pins_t  dout
);

  spisc_pkg::spisc_sync_s q, d;

  // A level moves only when stages two and three agree
  always_comb begin
    d    = q;
    d.q1 = din;
    d.q2 = q.q1;
    d.q3 = q.q2;
    for (int i = 0; i < 4; i++) begin
      if (q.q2[i] == q.q3[i]) begin
        d.st[i] = q.q3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= {4{`SPISC_SYNC_RST}};
    end else begin
      q <= d;
    end
  end

  assign dout = q.st;

endmodule : spisc_sync

// [logic/spisc_core.sv]
// SPI port: APB registers, master clocking and byte shifter
`timescale 1ns/1ps
`include "spisc_defines.svh"

module spisc_core #(
  parameter int AW = 12
) (
  // APB slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Serial pins
  input  wire logic          sck_in,
  output logic               sck_out,
  output logic               sck_oe,
  input  wire logic          sdi_in,
  output logic               sdo_out,
  output logic               sdo_oe,
  input  wire logic          slave_select_n_in,
  output logic               slave_select_n_out,
  output logic               slave_select_n_oe,
  // Master clock sources
  input  wire logic          sub_clock,
  input  wire logic          timer_period_match,
  // Interrupt request
  input  wire logic          irq_enable,
  output logic               irq_request
);

  spisc_pkg::spisc_core_s q, d;
  spisc_pkg::spisc_pins_t sy;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: [0] clock, [1] data in, [2] select, [3] sub-clock

  spisc_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({sub_clock, slave_select_n_in, sdi_in, sck_in}),
    .dout    (sy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b,
                                          input logic msb);
    shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
  endfunction : shift_in

  logic [2:0] msel;
  logic       en, master, slave, pol, eg, msb, select_pin_enable, busy;
  logic       selected, sck_rise, sck_fall, ssn_rise, sub_edge, cap_edge;
  logic       a_mode, a_link, a_data, hit, wr, rd_setup, wr_data;
  logic       tick, m_cap, m_done, s_done, inc_ev, hw_set;
  logic [5:0] half;

  assign msel   = q.mode[`SPISC_SEL_HI:`SPISC_SEL_LO];
  assign en     = q.mode[`SPISC_EN];
  assign master = en && (msel <= `SPISC_M_TMR);
  assign slave  = en && (msel == `SPISC_M_SLAVE);
  assign pol    = q.link[`SPISC_POL];
  assign eg     = q.link[`SPISC_EDGE];
  assign msb    = q.link[`SPISC_ORDER];
  assign select_pin_enable   = q.link[`SPISC_SELECT_PIN_ENABLE];
  assign busy   = q.st != spisc_pkg::SPISC_IDLE;

  assign selected = !select_pin_enable || !sy[2];
  assign sck_rise = sy[0] && !q.pin_d[0];
  assign sck_fall = !sy[0] && q.pin_d[0];
  assign ssn_rise = sy[2] && !q.pin_d[2];
  assign sub_edge = sy[3] ^ q.pin_d[3];
  // Capture is on the rising edge when polarity and edge bits match
  assign cap_edge = (pol == eg) ? sck_rise : sck_fall;

  assign a_mode   = paddr == `SPISC_OFF_MODE;
  assign a_link   = paddr == `SPISC_OFF_LINK;
  assign a_data   = paddr == `SPISC_OFF_DATA;
  assign hit      = a_mode || a_link || a_data;
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_data  = wr && a_data;

  always_comb begin
    unique case (msel)
      `SPISC_M_DIV4:  half = `SPISC_HALF_DIV4;
      `SPISC_M_DIV16: half = `SPISC_HALF_DIV16;
      default:        half = `SPISC_HALF_DIV64;
    endcase
  end

  // Half-period tick of the master clock
  assign tick = (msel == `SPISC_M_SUB) ? sub_edge :
                (msel == `SPISC_M_TMR) ? timer_period_match :
                (q.div == half - 6'h01);

  // Capture edges are the even ones when the edge bit is 1
  assign m_cap  = q.st == spisc_pkg::SPISC_MRUN && master && tick &&
                  q.edge_n != `SPISC_EDGES &&
                  (q.edge_n[0] != eg);
  // Done only once the last captured bit has left the synchroniser
  assign m_done = q.st == spisc_pkg::SPISC_MRUN && master &&
                  q.edge_n == `SPISC_EDGES && q.cap == 5'h00;
  assign s_done = slave && selected && cap_edge &&
                  q.bits == `SPISC_BITS - 4'h1;
  assign inc_ev = q.st == spisc_pkg::SPISC_SRUN && slave && select_pin_enable &&
                  ssn_rise;
  assign hw_set = m_done || s_done || inc_ev;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d       = q;
    d.pin_d = sy;
    d.irq   = hw_set && irq_enable;
    if (rd_setup) begin
      d.rdata = a_mode ? q.mode : a_link ? q.link : a_data ? q.data : 8'h00;
    end
    // Mode writes never touch the other registers
    if (wr && a_mode) begin
      d.mode = pwdata[7:0] & `SPISC_MODE_WMASK;
    end
    if (wr && a_link) begin
      d.link = pwdata[7:0];
    end
    if (wr_data) begin
      if (busy) begin
        d.link[`SPISC_WRITE_COLLISION_FLAG] = 1'b1;
      end else begin
        d.data = pwdata[7:0];
        if (master) begin
          d.st                = spisc_pkg::SPISC_MRUN;
          d.edge_n            = 5'h00;
          d.cap               = 5'h00;
          d.div               = 6'h00;
          d.link[`SPISC_TRF]  = 1'b0;
        end
      end
    end
    // Master: 16 clock edges; each capture is taken five cycles late,
    // since the input pin needs that long to cross the synchroniser.
    // Without it the fastest rate would read the previous bit.
    if (q.st == spisc_pkg::SPISC_MRUN && master) begin
      d.cap = {q.cap[3:0], m_cap};
      if (q.cap[4]) begin
        d.rx = shift_in(q.rx, sy[1], msb);
      end
      if (tick) begin
        d.div = 6'h00;
        if (q.edge_n != `SPISC_EDGES) begin
          d.sck    = ~q.sck;
          d.edge_n = q.edge_n + 5'h01;
        end
        // Next outgoing bit moves on each launch edge except edge 0
        if (q.edge_n != 5'h00 && q.edge_n[0] == eg) begin
          d.data = shift_in(q.data, 1'b0, msb);
        end
      end else if (msel <= `SPISC_M_DIV64) begin
        d.div = q.div + 6'h01;
      end
      if (m_done) begin
        d.st               = spisc_pkg::SPISC_IDLE;
        d.data             = q.rx;
        d.link[`SPISC_TRF] = 1'b1;
      end
    end else begin
      d.sck = ~pol;
    end
    // Slave: first edge while selected opens the transfer
    if (slave && selected && !(q.st == spisc_pkg::SPISC_MRUN)) begin
      if (q.st == spisc_pkg::SPISC_IDLE && (sck_rise || sck_fall)) begin
        d.st               = spisc_pkg::SPISC_SRUN;
        d.bits             = 4'h0;
        d.link[`SPISC_TRF] = 1'b0;
      end
      if (cap_edge) begin
        d.data = shift_in(q.data, sy[1], msb);
        d.bits = (q.st == spisc_pkg::SPISC_IDLE) ? 4'h1 : q.bits + 4'h1;
        if (s_done && q.st == spisc_pkg::SPISC_SRUN) begin
          d.st               = spisc_pkg::SPISC_IDLE;
          d.link[`SPISC_TRF] = 1'b1;
        end
      end
    end
    if (inc_ev) begin
      d.st               = spisc_pkg::SPISC_IDLE;
      d.mode[`SPISC_ICF] = 1'b1;
      d.link[`SPISC_TRF] = 1'b1;
    end
    // Leaving the mode or disabling aborts any transfer
    if ((q.st == spisc_pkg::SPISC_MRUN && !master) ||
        (q.st == spisc_pkg::SPISC_SRUN && !slave) || !en) begin
      d.st = spisc_pkg::SPISC_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.mode  <= `SPISC_MODE_RST;
      q.link  <= `SPISC_LINK_RST;
      q.data  <= `SPISC_DATA_RST;
      q.st    <= spisc_pkg::SPISC_IDLE;
      q.sck   <= 1'b1;
      q.pin_d <= `SPISC_SYNC_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata  = {24'h000000, q.rdata};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  assign sck_out            = q.sck;
  assign sck_oe             = master;
  assign sdo_oe             = master || slave;
  assign sdo_out            = (busy || (slave && selected)) ?
                              (msb ? q.data[7] : q.data[0]) : 1'b1;
  // Select is driven only by a master with the select pin enabled
  assign slave_select_n_oe  = master && select_pin_enable;
  assign slave_select_n_out = q.st != spisc_pkg::SPISC_MRUN;
  assign irq_request        = q.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [4:0] tog_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= 5'h00;
    end else if (q.st != spisc_pkg::SPISC_MRUN) begin
      tog_q <= 5'h00;
    end else if (d.sck != q.sck) begin
      tog_q <= tog_q + 5'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    master && !busy && wr_data;
  endsequence

  sequence s_running;
    q.st == spisc_pkg::SPISC_MRUN && !q.link[`SPISC_TRF];
  endsequence

  a_rsv_bit_zero: assert property (rd_setup && a_mode |=>
    prdata[`SPISC_RSV] == 1'b0) else $error("reserved bit set");
  a_pins_released: assert property (!en |->
    !sck_oe && !sdo_oe && !slave_select_n_oe) else $error("pin driven");
  a_collision_flag: assert property (wr_data && busy |=>
    q.link[`SPISC_WRITE_COLLISION_FLAG] && busy) else $error("collision missed");
  a_master_start: assert property (s_start |=> s_running)
    else $error("master did not start");
  a_idle_clock: assert property (sck_oe && !busy &&
    $past(!busy) && $stable(pol) |-> sck_out == ~pol)
    else $error("wrong idle clock level");
  a_incomplete_pair: assert property (inc_ev |=>
    q.mode[`SPISC_ICF] && q.link[`SPISC_TRF]) else $error("flags");
  a_sw_icf_only: assert property (wr && a_mode &&
    pwdata[`SPISC_ICF] && !q.link[`SPISC_TRF] && !hw_set && !wr_data |=>
    !q.link[`SPISC_TRF]) else $error("done flag set by software");
  a_select_float: assert property (!select_pin_enable |->
    !slave_select_n_oe) else $error("select driven");
  a_eight_bits: assert property (m_done |->
    tog_q == `SPISC_EDGES) else $error("wrong edge count");
  a_sdo_idle_high: assert property (master && !busy |->
    sdo_out) else $error("idle output low");
  a_irq_event: assert property (hw_set && irq_enable |=>
    irq_request ##1 !irq_request) else $error("interrupt missing");
  a_irq_quiet: assert property (!hw_set |=>
    !irq_request) else $error("interrupt without event");

  // Master framing: the last bit must land before the done flag
  sequence s_last_capture;
    m_cap && q.edge_n == `SPISC_EDGES - 5'h01;
  endsequence

  a_last_bit_kept: assert property (s_last_capture |->
    ##[1:8] m_done) else $error("last bit lost");
  a_select_low_run: assert property (master && select_pin_enable &&
    q.st == spisc_pkg::SPISC_MRUN |-> slave_select_n_oe &&
    !slave_select_n_out) else $error("select not low");

  // Flags stay until software clears them; the first edge of a slave transfer also clears the done flag
  a_done_sticky: assert property (q.link[`SPISC_TRF] && !wr &&
    !(slave && (sck_rise || sck_fall)) |=> q.link[`SPISC_TRF])
    else $error("done flag lost");
  a_collision_kept: assert property (q.link[`SPISC_WRITE_COLLISION_FLAG] && !wr |=>
    q.link[`SPISC_WRITE_COLLISION_FLAG]) else $error("collision flag lost");

  // Slave closing, disable, pin ownership and mode writes
  a_slave_close: assert property (s_done &&
    q.st == spisc_pkg::SPISC_SRUN |=> q.link[`SPISC_TRF] && !busy)
    else $error("slave byte not closed");
  a_disable_idle: assert property (!en |=> !busy)
    else $error("busy while disabled");
  a_slave_sck_float: assert property (slave |-> !sck_oe)
    else $error("slave drives clock");
  a_mode_keeps_link: assert property (wr && a_mode && !busy &&
    !slave |=> q.link == $past(q.link))
    else $error("link changed by mode write");

endmodule : spisc_core

// [tb/spisc_slave_model.sv]
// Behavioural SPI slave that answers the port in master mode
`timescale 1ns/1ps

module spisc_slave_model (
  // Serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ssn,
  output logic            miso,
  // Frame setup and data
  input  wire logic       pol,
  input  wire logic       edge_b,
  input  wire logic       msb,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx
);
  int n = 0;
  initial miso = 1'h1;
  function automatic logic pick(input int i);
    return msb ? tx[7-i] : tx[i];
  endfunction : pick
  always @(negedge ssn) begin
    n = 0;
    miso = pick(0);
  end
  always @(sck) begin
    if (!ssn && sck == (pol == edge_b)) begin
      rx = msb ? {rx[6:0], mosi} : {mosi, rx[7:1]};
      n++;
    end else if (!ssn && n > 0 && n < 8) begin
      miso = pick(n);
    end
  end
  // Released line must not keep its last value
  always @(posedge ssn) miso = ~miso;
endmodule : spisc_slave_model

// [tb/spisc_bench.sv]
// Self-checking bench for the SPI port: registers, master and slave
`timescale 1ns/1ps
`include "spisc_defines.svh"

module spisc_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        sck_in, sck_out, sck_oe, sdi_in, sdi_m, sdi_w, sdo_out, sdo_oe;
  logic        ssn_in, ssn_out, ssn_oe, ssn_w, sub_clock, timer_period_match;
  logic        irq_request, pol, edge_b, msb, slv_m;
  logic  [7:0] tx, rx, got, d, lk;
  int          fails, num_checks, irqs, tcnt, m;

  assign ssn_w = ssn_oe ? ssn_out : 1'h1;
  assign sdi_w = slv_m ? sdi_in : sdi_m;
  spisc_core #(.AW(12)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_w),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .slave_select_n_in(ssn_in),
    .slave_select_n_out(ssn_out), .slave_select_n_oe(ssn_oe),
    .sub_clock(sub_clock), .timer_period_match(timer_period_match),
    .irq_enable(1'h1), .irq_request(irq_request));
  spisc_slave_model PART (.sck(sck_out), .mosi(sdo_out), .ssn(ssn_w),
    .miso(sdi_m), .pol(pol), .edge_b(edge_b), .msb(msb), .tx(tx), .rx(rx));

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // Slow free-running sources for the sub-clock and timer modes
  always @(posedge pclk) begin
    tcnt <= tcnt + 1;
    timer_period_match <= (tcnt % 6 == 0);
    if (tcnt % 5 == 0) sub_clock <= ~sub_clock;
    if (irq_request === 1'h1) irqs <= irqs + 1;
  end

  task automatic chk(input string s, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] v);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    serr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  // Polling bounded so a stuck transfer reports instead of hanging
  task automatic wait_done();
    for (int i = 0; i < 400; i++) begin
      apb(1'h0, `SPISC_OFF_LINK, 8'h00);
      if (r[0] === 1'h1) break;
    end
  endtask : wait_done
  // Acts as external master: idle high, capture on rising edges
  task automatic slv(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) begin
      if (k % 2 == 0) sdi_in <= b[7-k/2];
      else got = {got[6:0], sdo_out};
      sck_in <= k[0];
      repeat (8) @(posedge pclk);
    end
  endtask : slv
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    {presetn, psel, penable, pwrite, sub_clock, pol, edge_b, slv_m} = 8'h00;
    {sck_in, sdi_in, ssn_in, msb} = 4'hF;
    {paddr, pwdata, tx, fails, num_checks, irqs, tcnt} = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, `SPISC_OFF_MODE, 8'h00);
    chk("mode reset", r, 32'hE0);
    apb(1'h1, `SPISC_OFF_MODE, 8'hFC);
    apb(1'h0, `SPISC_OFF_MODE, 8'h00);
    chk("mode bit4", r, 32'hEC);
    apb(1'h1, `SPISC_OFF_LINK, 8'hC4);
    apb(1'h1, `SPISC_OFF_MODE, 8'h00);
    chk("pins off", {29'h0, sck_oe, sdo_oe, ssn_oe}, 32'h0);
    apb(1'h0, `SPISC_OFF_LINK, 8'h00);
    chk("link storage", r, 32'hC4);
    apb(1'h1, 12'h00C, 8'h55);
    chk("unmapped err", {31'h0, serr}, 32'h1);
    for (m = 0; m < 5; m++) begin
      pol    <= m[0];
      edge_b <= m[1];
      msb    <= m[0] ^ m[1];
      tx     <= 8'h96 ^ {5'h0, m[2:0]};
      d = 8'h3C ^ {m[2:0], 5'h0};
      lk = {2'h0, m[0], m[1], m[0] ^ m[1], 3'h4};
      apb(1'h1, `SPISC_OFF_LINK, lk);
      apb(1'h1, `SPISC_OFF_MODE, {m[2:0], 5'h02});
      apb(1'h0, `SPISC_OFF_LINK, 8'h00);
      chk("link kept", r, {24'h0, lk});
      chk("sck idle", {31'h0, sck_out}, {31'h0, ~m[0]});
      chk("sdo idle", {30'h0, sdo_out, sck_oe}, 32'h3);
      apb(1'h1, `SPISC_OFF_DATA, d);
      apb(1'h1, `SPISC_OFF_DATA, 8'hFF);
      apb(1'h0, `SPISC_OFF_LINK, 8'h00);
      chk("busy flags", {29'h0, ssn_w, r[1:0]}, 32'h2);
      wait_done();
      chk("done flags", {30'h0, r[1:0]}, 32'h3);
      apb(1'h0, `SPISC_OFF_DATA, 8'h00);
      chk("master rx", r, {24'h0, tx});
      chk("master tx", {24'h0, rx}, {24'h0, d});
      chk("done irq", irqs, m + 1);
    end
    apb(1'h1, `SPISC_OFF_LINK, 8'h00);
    chk("select float", {31'h0, ssn_oe}, 32'h0);
    slv_m <= 1'h1;
    apb(1'h1, `SPISC_OFF_LINK, 8'h08);
    apb(1'h1, `SPISC_OFF_MODE, 8'hA2);
    apb(1'h1, `SPISC_OFF_DATA, 8'h5A);
    slv(16, 8'hC3);
    apb(1'h0, `SPISC_OFF_DATA, 8'h00);
    chk("slave rx", r, 32'hC3);
    chk("slave tx", {24'h0, got}, 32'h5A);
    apb(1'h1, `SPISC_OFF_LINK, 8'h0C);
    ssn_in <= 1'h0;
    repeat (8) @(posedge pclk);
    slv(4, 8'h00);
    ssn_in <= 1'h1;
    repeat (10) @(posedge pclk);
    apb(1'h0, `SPISC_OFF_MODE, 8'h00);
    chk("incomplete", r, 32'hA3);
    apb(1'h0, `SPISC_OFF_LINK, 8'h00);
    chk("early done", r, 32'h0D);
    chk("abort irq", irqs, 7);
    apb(1'h1, `SPISC_OFF_LINK, 8'h0C);
    apb(1'h1, `SPISC_OFF_MODE, 8'hA2);
    apb(1'h1, `SPISC_OFF_MODE, 8'hA3);
    apb(1'h0, `SPISC_OFF_LINK, 8'h00);
    chk("sw icf", r, 32'h0C);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end
endmodule : spisc_bench
